//--- hw/lcdiu_pkg.sv
// Shared constants and types of the character display instruction unit.
// Summary of operation
// - Data access steps address after busy plus delay
// - Execution times scale inversely with oscillator frequency
// - Clear fills spaces, zeroes address, cancels shift
// - Clear forces increment, keeps auto shift
// - Home zeroes address and shift, keeps RAM
// - Entry direction increments or decrements on access
// - Cursor follows address up or down
// - Auto shift moves display on character writes
// - No auto shift on reads or glyph access
// - Display enable blanks without touching RAM
// - Cursor row eight, or eleven for the 5x10 font on one line
// - Blink toggles at scaled interval, coexists cursor
// - Two-line cursor wraps past digit forty
// - Display shift moves both lines horizontally
// - Display-only shift keeps address unchanged
// - Eight lines or two upper-nibble transfers
// - Glyph address set loads six bits, selects glyphs
// - Character address set selects character RAM
// - Valid character addresses depend on line mode
// - While busy only the status read works
// - Status read returns busy and address instantly
// - Shift target picks cursor or display move
// - Line and font select give the duty
package lcdiu_pkg;
  localparam int unsigned LCDIU_CLK_PERIOD_NS = 5;
  localparam longint LCDIU_OSC_KHZ = 270;
  localparam longint LCDIU_EXEC_REF_KHZ = 270;
  localparam longint LCDIU_BLINK_REF_KHZ = 250;
  localparam longint LCDIU_T_EXEC_NS = 37000;
  localparam longint LCDIU_T_HOME_NS = 1520000;
  localparam longint LCDIU_T_ADD_NS = 4000;
  localparam longint LCDIU_T_BLINK_NS = 409600000;
  localparam longint LCDIU_DEN_EXEC = LCDIU_CLK_PERIOD_NS * LCDIU_OSC_KHZ;
  localparam int unsigned LCDIU_EXEC_CYC = 32'((LCDIU_T_EXEC_NS * LCDIU_EXEC_REF_KHZ
    + LCDIU_DEN_EXEC - 1) / LCDIU_DEN_EXEC);
  localparam int unsigned LCDIU_HOME_CYC = 32'((LCDIU_T_HOME_NS * LCDIU_EXEC_REF_KHZ
    + LCDIU_DEN_EXEC - 1) / LCDIU_DEN_EXEC);
  localparam int unsigned LCDIU_BLINK_CYC = 32'(LCDIU_T_BLINK_NS * LCDIU_BLINK_REF_KHZ
    / LCDIU_DEN_EXEC);
  localparam int unsigned LCDIU_ADD_CYC = 32'((LCDIU_T_ADD_NS + LCDIU_CLK_PERIOD_NS - 1)
    / LCDIU_CLK_PERIOD_NS);
  localparam int unsigned LCDIU_FIFO_DEPTH = 8;
  // Instruction class is the highest set bit of the byte.
  localparam int unsigned LCDIU_B_CHAR = 7;
  localparam int unsigned LCDIU_B_GLYPH = 6;
  localparam int unsigned LCDIU_B_FUNC = 5;
  localparam int unsigned LCDIU_B_SHIFT = 4;
  localparam int unsigned LCDIU_B_DISP = 3;
  localparam int unsigned LCDIU_B_ENTRY = 2;
  localparam int unsigned LCDIU_B_HOME = 1;
  localparam int unsigned LCDIU_B_CLEAR = 0;
  localparam int unsigned LCDIU_FS_WIDTH = 4;
  localparam int unsigned LCDIU_FS_LINES = 3;
  localparam int unsigned LCDIU_FS_FONT = 2;
  localparam int unsigned LCDIU_SH_TARGET = 3;
  localparam int unsigned LCDIU_SH_DIR = 2;
  localparam int unsigned LCDIU_DC_DISP = 2;
  localparam int unsigned LCDIU_DC_CURS = 1;
  localparam int unsigned LCDIU_DC_BLINK = 0;
  localparam int unsigned LCDIU_EM_DIR = 1;
  localparam int unsigned LCDIU_EM_SHIFT = 0;
  localparam logic [6:0] LCDIU_L1_END = 7'h27;
  localparam logic [6:0] LCDIU_L2_BASE = 7'h40;
  localparam logic [6:0] LCDIU_L2_END = 7'h67;
  localparam logic [6:0] LCDIU_ONE_END = 7'h4F;
  localparam logic [6:0] LCDIU_L2_IDX = 7'h28;
  localparam logic [6:0] LCDIU_CRAM_N = 7'h50;
  localparam logic [5:0] LCDIU_OFS_MAX = 6'h27;
  localparam logic [7:0] LCDIU_SPACE = 8'h20;
  localparam logic [3:0] LCDIU_ROW_5X8 = 4'h7;
  localparam logic [3:0] LCDIU_ROW_5X10 = 4'hA;
  localparam logic [4:0] LCDIU_DUTY_8 = 5'h08;
  localparam logic [4:0] LCDIU_DUTY_11 = 5'h0B;
  localparam logic [4:0] LCDIU_DUTY_16 = 5'h10;
  localparam logic LCDIU_RST_WIDTH = 1'b1;
  localparam logic LCDIU_RST_INC = 1'b1;

  typedef struct packed {
    logic rs;
    logic rw;
    logic [7:0] data;
  } lcdiu_cmd_t;

  typedef struct packed {
    logic display_on;
    logic cursor_on;
    logic blink_on;
    logic blink_show;
    logic two_line;
    logic font_5x10;
    logic [3:0] cursor_row;
    logic [4:0] duty_div;
    logic [5:0] shift_ofs;
    logic [6:0] cursor_addr;
  } lcdiu_disp_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CLEAR = 2'b01,
    ST_EXEC = 2'b10,
    ST_ADD = 2'b11
  } lcdiu_st_t;
endpackage

//--- hw/lcdiu_fifo.sv
// Command FIFO between the host pin capture and the instruction engine.
`timescale 1ns/1ps
module lcdiu_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 8
) (
  input wire logic i_sys_clk, // System clock.
  input wire logic i_rstn, // Asynchronous reset, active low.
  input wire logic i_valid, // Write side valid.
  output logic o_ready, // Write side ready.
  input wire logic [WIDTH-1:0] i_data, // Write side word.
  output logic o_valid, // Read side valid.
  input wire logic i_ready, // Read side ready.
  output logic [WIDTH-1:0] o_data // Read side word.
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } lcdiu_fifo_st_t;
  lcdiu_fifo_st_t s_q;
  lcdiu_fifo_st_t s_d;
  logic push;
  logic pop;

  assign o_ready = s_q.cnt != (AW+1)'(DEPTH);
  assign o_valid = s_q.cnt != '0;
  assign o_data = s_q.mem[s_q.rp];
  assign push = i_valid & o_ready;
  assign pop = o_valid & i_ready;

  always_comb
  begin
    s_d = s_q;
    if (push)
    begin
      s_d.mem[s_q.wp] = i_data;
      s_d.wp = (s_q.wp == AW'(DEPTH - 1)) ? '0 : s_q.wp + 1'b1;
    end
    if (pop)
    begin
      s_d.rp = (s_q.rp == AW'(DEPTH - 1)) ? '0 : s_q.rp + 1'b1;
    end
    if (push & ~pop)
    begin
      s_d.cnt = s_q.cnt + 1'b1;
    end
    else if (pop & ~push)
    begin
      s_d.cnt = s_q.cnt - 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end
endmodule // lcdiu_fifo

//--- hw/lcdiu_top.sv
// Instruction interpreter of the character display controller, host pins to display state.
`timescale 1ns/1ps
module lcdiu_top
  import lcdiu_pkg::*;
#(
  parameter int unsigned EXEC_CYC = LCDIU_EXEC_CYC,
  parameter int unsigned HOME_CYC = LCDIU_HOME_CYC,
  parameter int unsigned BLINK_CYC = LCDIU_BLINK_CYC
) (
  input wire logic i_sys_clk, // System clock, 200 MHz.
  input wire logic i_rstn, // Asynchronous reset, active low.
  input wire logic i_en, // Host enable strobe pin.
  input wire logic i_reg_select, // Host register select pin.
  input wire logic i_read_write_sel, // Host read high, write low.
  input wire logic [7:0] i_db, // Host data lines in.
  output logic [7:0] o_db, // Host data lines out.
  output logic o_db_oe, // High while the unit drives the data lines.
  input wire logic [6:0] i_scan_idx, // Character storage index for the scanner.
  output logic [7:0] o_scan_data, // Character code at the scan index.
  input wire logic [5:0] i_gscan_addr, // Glyph RAM address for the scanner.
  output logic [7:0] o_gscan_data, // Glyph row at the scan address.
  output lcdiu_disp_t o_disp, // Display control state.
  output logic o_busy_flag // Engine busy.
);
  typedef struct packed {
    logic [2:0] en_p;
    logic [1:0] rs_p;
    logic [1:0] rw_p;
    logic [1:0][7:0] db_p;
    logic nib_lo;
    logic [3:0] nib_hi;
    logic push;
    lcdiu_cmd_t cmd;
    lcdiu_st_t st;
    logic [31:0] cnt;
    logic [6:0] ac;
    logic glyph_sel;
    logic inc;
    logic auto_shift;
    logic bus_width_sel;
    logic step_pend;
    logic [6:0] clr_idx;
    logic [31:0] blink_cnt;
    logic busy_flag;
    logic [7:0] db_o;
    logic db_oe;
    logic [7:0] scan;
    logic [7:0] gscan;
    lcdiu_disp_t disp;
    logic [79:0][7:0] cram;
    logic [63:0][7:0] gram;
  } lcdiu_state_t;

  lcdiu_state_t s_q;
  lcdiu_state_t s_d;
  logic fifo_ready;
  logic fifo_valid;
  logic pop;
  lcdiu_cmd_t fifo_cmd;

  // Storage index of a character address; two-line mode packs line two behind line one.
  function automatic logic [6:0] f_idx(input logic [6:0] a, input logic two);
    logic [6:0] r;
    r = a;
    if (two && a >= LCDIU_L2_BASE)
    begin
      r = a - LCDIU_L2_BASE + LCDIU_L2_IDX;
    end
    else if (two && a > LCDIU_L1_END)
    begin
      r = LCDIU_CRAM_N;
    end
    return r;
  endfunction

  // Next address after one step, wrapping inside the valid window of the current RAM.
  function automatic logic [6:0] f_step(input logic [6:0] a, input logic up,
                                        input logic two, input logic glyph);
    logic [6:0] r;
    r = up ? a + 7'h01 : a - 7'h01;
    if (glyph)
    begin
      r = {1'b0, r[5:0]};
    end
    else if (two)
    begin
      if (up && a == LCDIU_L1_END)
      begin
        r = LCDIU_L2_BASE;
      end
      else if (up && a >= LCDIU_L2_END)
      begin
        r = '0;
      end
      else if (!up && a == LCDIU_L2_BASE)
      begin
        r = LCDIU_L1_END;
      end
      else if (!up && a == '0)
      begin
        r = LCDIU_L2_END;
      end
    end
    else if (up && a >= LCDIU_ONE_END)
    begin
      r = '0;
    end
    else if (!up && a == '0)
    begin
      r = LCDIU_ONE_END;
    end
    return r;
  endfunction

  // Left display shift raises the offset; one offset serves both lines.
  function automatic logic [5:0] f_ofs(input logic [5:0] o, input logic right);
    logic [5:0] r;
    r = right ? o - 6'h01 : o + 6'h01;
    if (right && o == '0)
    begin
      r = LCDIU_OFS_MAX;
    end
    else if (!right && o >= LCDIU_OFS_MAX)
    begin
      r = '0;
    end
    return r;
  endfunction

  lcdiu_fifo #(
    .WIDTH($bits(lcdiu_cmd_t)),
    .DEPTH(LCDIU_FIFO_DEPTH)
  ) lcdiu_fifo_inst (
    .i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .i_valid(s_q.push),
    .o_ready(fifo_ready),
    .i_data(s_q.cmd),
    .o_valid(fifo_valid),
    .i_ready(pop),
    .o_data(fifo_cmd)
  );

  assign pop = fifo_valid & (s_q.st == ST_IDLE);

  always_comb
  begin
    logic en_rise;
    logic en_fall;
    logic two;
    logic done;
    logic [7:0] byte_in;
    logic [7:0] rd_byte;
    logic [6:0] idx;
    logic [7:0] d;
    en_rise = 1'b0;
    en_fall = 1'b0;
    two = 1'b0;
    done = 1'b0;
    byte_in = '0;
    rd_byte = '0;
    idx = '0;
    d = '0;
    s_d = s_q;
    two = s_q.disp.two_line;
    s_d.en_p = {s_q.en_p[1:0], i_en};
    s_d.rs_p = {s_q.rs_p[0], i_reg_select};
    s_d.rw_p = {s_q.rw_p[0], i_read_write_sel};
    s_d.db_p = {s_q.db_p[0], i_db};
    en_rise = s_q.en_p[1] & ~s_q.en_p[2];
    en_fall = ~s_q.en_p[1] & s_q.en_p[2];
    s_d.push = 1'b0;
    idx = f_idx(s_q.ac, two);
    if (s_q.glyph_sel)
    begin
      rd_byte = s_q.gram[s_q.ac[5:0]];
    end
    else if (idx < LCDIU_CRAM_N)
    begin
      rd_byte = s_q.cram[idx];
    end
    if (!s_q.rs_p[1])
    begin
      rd_byte = {s_q.busy_flag, s_q.ac};
    end
    // Host side: drive on the strobe's rise, take the byte on its fall.
    if (en_rise && s_q.rw_p[1])
    begin
      s_d.db_oe = 1'b1;
      s_d.db_o = rd_byte;
      if (!s_q.bus_width_sel)
      begin
        s_d.db_o = {s_q.nib_lo ? rd_byte[3:0] : rd_byte[7:4], 4'h0};
      end
    end
    if (en_fall)
    begin
      s_d.db_oe = 1'b0;
      byte_in = s_q.db_p[1];
      done = 1'b1;
      if (!s_q.bus_width_sel)
      begin
        s_d.nib_lo = ~s_q.nib_lo;
        s_d.nib_hi = s_q.db_p[1][7:4];
        byte_in = {s_q.nib_hi, s_q.db_p[1][7:4]};
        done = s_q.nib_lo;
      end
      // Everything but the status read is dropped while busy or while the queue is full.
      if (done && (s_q.rs_p[1] || !s_q.rw_p[1]) && !s_q.busy_flag && fifo_ready)
      begin
        s_d.push = 1'b1;
        s_d.cmd = '{rs: s_q.rs_p[1], rw: s_q.rw_p[1], data: byte_in};
      end
    end
    // Engine.
    case (s_q.st)
      ST_IDLE:
      begin
        if (fifo_valid)
        begin
          d = fifo_cmd.data;
          s_d.st = ST_EXEC;
          s_d.cnt = EXEC_CYC;
          if (fifo_cmd.rs)
          begin
            s_d.step_pend = 1'b1;
            if (!fifo_cmd.rw)
            begin
              if (s_q.glyph_sel)
              begin
                s_d.gram[s_q.ac[5:0]] = d;
              end
              else
              begin
                if (idx < LCDIU_CRAM_N)
                begin
                  s_d.cram[idx] = d;
                end
                if (s_q.auto_shift)
                begin
                  s_d.disp.shift_ofs = f_ofs(s_q.disp.shift_ofs, ~s_q.inc);
                end
              end
            end
          end
          else if (d[LCDIU_B_CHAR])
          begin
            s_d.ac = d[6:0];
            s_d.glyph_sel = 1'b0;
          end
          else if (d[LCDIU_B_GLYPH])
          begin
            s_d.ac = {1'b0, d[5:0]};
            s_d.glyph_sel = 1'b1;
          end
          else if (d[LCDIU_B_FUNC])
          begin
            s_d.bus_width_sel = d[LCDIU_FS_WIDTH];
            s_d.nib_lo = 1'b0;
            s_d.disp.two_line = d[LCDIU_FS_LINES];
            s_d.disp.font_5x10 = d[LCDIU_FS_FONT];
          end
          else if (d[LCDIU_B_SHIFT])
          begin
            if (d[LCDIU_SH_TARGET])
            begin
              s_d.disp.shift_ofs = f_ofs(s_q.disp.shift_ofs, d[LCDIU_SH_DIR]);
            end
            else
            begin
              s_d.ac = f_step(s_q.ac, d[LCDIU_SH_DIR], two, s_q.glyph_sel);
            end
          end
          else if (d[LCDIU_B_DISP])
          begin
            s_d.disp.display_on = d[LCDIU_DC_DISP];
            s_d.disp.cursor_on = d[LCDIU_DC_CURS];
            s_d.disp.blink_on = d[LCDIU_DC_BLINK];
          end
          else if (d[LCDIU_B_ENTRY])
          begin
            s_d.inc = d[LCDIU_EM_DIR];
            s_d.auto_shift = d[LCDIU_EM_SHIFT];
          end
          else if (d[LCDIU_B_HOME])
          begin
            s_d.ac = '0;
            s_d.glyph_sel = 1'b0;
            s_d.disp.shift_ofs = '0;
            s_d.cnt = HOME_CYC;
          end
          else if (d[LCDIU_B_CLEAR])
          begin
            s_d.st = ST_CLEAR;
            s_d.clr_idx = '0;
            s_d.ac = '0;
            s_d.glyph_sel = 1'b0;
            s_d.disp.shift_ofs = '0;
            s_d.inc = 1'b1;
            s_d.cnt = HOME_CYC;
          end
          else
          begin
            s_d.st = ST_IDLE;
          end
        end
      end
      ST_CLEAR:
      begin
        s_d.cram[s_q.clr_idx] = LCDIU_SPACE;
        s_d.clr_idx = s_q.clr_idx + 7'h01;
        if (s_q.clr_idx == LCDIU_CRAM_N - 7'h01)
        begin
          s_d.st = ST_EXEC;
        end
      end
      ST_EXEC:
      begin
        s_d.cnt = s_q.cnt - 32'h1;
        if (s_q.cnt <= 32'h1)
        begin
          s_d.st = s_q.step_pend ? ST_ADD : ST_IDLE;
          s_d.cnt = LCDIU_ADD_CYC;
        end
      end
      ST_ADD:
      begin
        // The address moves only after the busy flag has dropped.
        s_d.cnt = s_q.cnt - 32'h1;
        if (s_q.cnt <= 32'h1)
        begin
          s_d.ac = f_step(s_q.ac, s_q.inc, two, s_q.glyph_sel);
          s_d.step_pend = 1'b0;
          s_d.st = ST_IDLE;
        end
      end
      default:
      begin
        s_d.st = ST_IDLE;
      end
    endcase
    // A byte on its way into the queue counts as busy too, or busy would dip for a cycle.
    s_d.busy_flag = s_d.push | s_q.push | fifo_valid | (s_d.st == ST_EXEC)
      | (s_d.st == ST_CLEAR);
    s_d.blink_cnt = s_q.blink_cnt + 32'h1;
    if (s_q.blink_cnt >= BLINK_CYC - 1)
    begin
      s_d.blink_cnt = '0;
      s_d.disp.blink_show = ~s_q.disp.blink_show;
    end
    s_d.disp.cursor_row = (s_d.disp.font_5x10 && !s_d.disp.two_line) ?
      LCDIU_ROW_5X10 : LCDIU_ROW_5X8;
    s_d.disp.duty_div = s_d.disp.two_line ? LCDIU_DUTY_16 :
      (s_d.disp.font_5x10 ? LCDIU_DUTY_11 : LCDIU_DUTY_8);
    s_d.disp.cursor_addr = s_q.ac;
    s_d.scan = (i_scan_idx < LCDIU_CRAM_N) ? s_q.cram[i_scan_idx] : LCDIU_SPACE;
    s_d.gscan = s_q.gram[i_gscan_addr];
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      s_q <= '0;
      s_q.st <= ST_IDLE;
      s_q.inc <= LCDIU_RST_INC;
      s_q.bus_width_sel <= LCDIU_RST_WIDTH;
      s_q.cram <= {80{LCDIU_SPACE}};
      s_q.disp.cursor_row <= LCDIU_ROW_5X8;
      s_q.disp.duty_div <= LCDIU_DUTY_8;
      s_q.scan <= LCDIU_SPACE;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign o_db = s_q.db_o;
  assign o_db_oe = s_q.db_oe;
  assign o_scan_data = s_q.scan;
  assign o_gscan_data = s_q.gscan;
  assign o_disp = s_q.disp;
  assign o_busy_flag = s_q.busy_flag;
endmodule // lcdiu_top

//--- bench/lcdiu_assertions.sv
// Port-level assertions of the display instruction unit.
`timescale 1ns/1ps
module lcdiu_assertions
  import lcdiu_pkg::*;
#(
  parameter int unsigned EXEC_CYC = LCDIU_EXEC_CYC,
  parameter int unsigned BLINK_CYC = LCDIU_BLINK_CYC
) (
  input wire logic i_sys_clk, // System clock.
  input wire logic i_rstn, // Reset, active low.
  input wire logic o_db_oe, // Read drive enable.
  input wire logic [7:0] o_scan_data, // Scanner character code.
  input wire lcdiu_disp_t o_disp, // Display state.
  input wire logic o_busy_flag // Engine busy.
);
  logic [31:0] busy_run_q;
  logic [31:0] blink_age_q;
  logic show_q;
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      busy_run_q <= 32'h0;
      blink_age_q <= 32'h0;
      show_q <= 1'b0;
    end
    else
    begin
      busy_run_q <= o_busy_flag ? busy_run_q + 32'h1 : 32'h0;
      show_q <= o_disp.blink_show;
      blink_age_q <= (!o_disp.blink_on || o_disp.blink_show != show_q) ? 32'h0
        : blink_age_q + 32'h1;
    end
  end
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  property p_oe_stands;
    $rose(o_db_oe) |=> o_db_oe;
  endproperty
  property p_exec_len;
    $fell(o_busy_flag) |-> busy_run_q >= EXEC_CYC;
  endproperty
  property p_blink_period;
    o_disp.blink_on |-> blink_age_q <= BLINK_CYC;
  endproperty
  property p_duty;
    o_disp.duty_div == (o_disp.two_line ? LCDIU_DUTY_16
      : (o_disp.font_5x10 ? LCDIU_DUTY_11 : LCDIU_DUTY_8));
  endproperty
  property p_cursor_row;
    o_disp.cursor_on |-> o_disp.cursor_row
      == ((o_disp.font_5x10 && !o_disp.two_line) ? LCDIU_ROW_5X10 : LCDIU_ROW_5X8);
  endproperty
  property p_shift_keeps_addr;
    $changed(o_disp.shift_ofs) && o_disp.shift_ofs != 6'h00
      |-> $stable(o_disp.cursor_addr) [*3];
  endproperty
  property p_addr_late;
    $fell(o_busy_flag) |-> ##2 $stable(o_disp.cursor_addr) [*6];
  endproperty
  property p_ofs_range;
    o_disp.shift_ofs <= LCDIU_OFS_MAX;
  endproperty
  property p_display_keeps_ram;
    $changed(o_disp.display_on) |-> $stable(o_scan_data) [*4];
  endproperty
  a_oe_stands: assert property (p_oe_stands) else $error("read drive too short");
  a_exec_len: assert property (p_exec_len) else $error("busy too short");
  a_blink_period: assert property (p_blink_period) else $error("blink late");
  a_duty: assert property (p_duty) else $error("duty mismatch");
  a_cursor_row: assert property (p_cursor_row) else $error("cursor row wrong");
  a_shift_keeps_addr: assert property (p_shift_keeps_addr) else $error("shift moved address");
  a_addr_late: assert property (p_addr_late) else $error("address stepped early");
  a_ofs_range: assert property (p_ofs_range) else $error("shift offset range");
  a_display_keeps_ram: assert property (p_display_keeps_ram) else $error("ram changed");
  c_blink: cover property ($changed(o_disp.blink_show) && o_disp.blink_on);
  c_shift: cover property ($changed(o_disp.shift_ofs));
  c_read: cover property ($rose(o_db_oe));
endmodule // lcdiu_assertions

bind lcdiu_top lcdiu_assertions #(.EXEC_CYC(EXEC_CYC), .BLINK_CYC(BLINK_CYC))
  lcdiu_assertions_inst (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .o_db_oe(o_db_oe),
  .o_scan_data(o_scan_data), .o_disp(o_disp), .o_busy_flag(o_busy_flag));

//--- bench/lcdiu_host_model.sv
// Host processor model that drives the strobe, select and data pins.
`timescale 1ns/1ps
module lcdiu_host_model (
  input wire logic i_sys_clk, // System clock.
  input wire logic [7:0] i_db, // Read data from the unit.
  output logic o_en, // Strobe pin.
  output logic o_reg_select, // Register select pin.
  output logic o_read_write_sel, // Read high, write low.
  output logic [7:0] o_db // Data lines toward the unit.
);
  logic wide;
  initial
  begin
    wide = 1'b1;
    o_en = 1'b0;
    o_reg_select = 1'b0;
    o_read_write_sel = 1'b0;
    o_db = 8'h00;
  end
  // Data is held well past the fall, since the pins pass a synchroniser.
  task automatic strobe(input logic rs, input logic rw, input logic [7:0] d,
    output logic [7:0] q);
    @(posedge i_sys_clk);
    o_reg_select <= rs;
    o_read_write_sel <= rw;
    o_db <= rw ? ~o_db : d;
    o_en <= 1'b1;
    repeat (6) @(posedge i_sys_clk);
    q = i_db;
    o_en <= 1'b0;
    repeat (5) @(posedge i_sys_clk);
    o_db <= ~o_db;
  endtask
  // Lower lines carry junk in narrow mode so that using them would show.
  task automatic xfer(input logic rs, input logic rw, input logic [7:0] d,
    output logic [7:0] q);
    logic [7:0] hi;
    logic [7:0] lo;
    if (wide)
    begin
      strobe(rs, rw, d, q);
    end
    else
    begin
      strobe(rs, rw, {d[7:4], ~d[7:4]}, hi);
      strobe(rs, rw, {d[3:0], ~d[3:0]}, lo);
      q = {hi[7:4], lo[7:4]};
    end
    if (!rs && !rw && d[7:5] == 3'b001)
    begin
      wide = d[4];
    end
  endtask
endmodule // lcdiu_host_model

//--- bench/tb_top.sv
// Self-checking testbench of the display instruction unit.
`timescale 1ns/1ps
module tb_top
  import lcdiu_pkg::*;
;
  localparam int unsigned T_BLINK = 16;
  localparam logic [23:0] SH_TAB [4] = '{24'h180127, 24'h1C0027, 24'h100026, 24'h140027};
  logic i_sys_clk;
  logic i_rstn;
  logic en;
  logic rs;
  logic rw;
  logic [7:0] db_in;
  logic [7:0] db_out;
  logic [6:0] scan_idx;
  logic [7:0] scan_data;
  logic [5:0] gscan_addr;
  logic [7:0] gscan_data;
  lcdiu_disp_t disp;
  logic busy;
  logic db_oe;
  logic oe_seen;
  logic [7:0] rdq;
  logic [7:0] got;
  logic [6:0] ac;
  logic blink_was;
  int n;
  int n_mismatch;
  int checks_done;
  lcdiu_top #(.EXEC_CYC(20), .HOME_CYC(40), .BLINK_CYC(T_BLINK)) lcdiu_top_inst (
    .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_en(en), .i_reg_select(rs),
    .i_read_write_sel(rw), .i_db(db_in), .o_db(db_out), .o_db_oe(db_oe),
    .i_scan_idx(scan_idx), .o_scan_data(scan_data), .i_gscan_addr(gscan_addr),
    .o_gscan_data(gscan_data), .o_disp(disp), .o_busy_flag(busy));
  lcdiu_host_model lcdiu_host_model_inst (.i_sys_clk(i_sys_clk), .i_db(db_out),
    .o_en(en), .o_reg_select(rs), .o_read_write_sel(rw), .o_db(db_in));
  initial
  begin
    i_sys_clk = 1'b0;
    forever #2.5 i_sys_clk = ~i_sys_clk;
  end
  always @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      oe_seen <= 1'b0;
    end
    else if (db_oe)
    begin
      oe_seen <= 1'b1;
    end
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
    begin
      $display("verification passed");
    end
    else
    begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic ofs(input logic [7:0] e);
    chk("shift offset", e, {2'h0, disp.shift_ofs});
  endtask
  task automatic poll();
    for (int i = 0; i < 100; i++)
    begin
      lcdiu_host_model_inst.xfer(1'b0, 1'b1, 8'h00, rdq);
      if (rdq[7] === 1'b0)
      begin
        ac = rdq[6:0];
        return;
      end
    end
    n_mismatch++;
    $display("Error busy poll expected 0 seen 1");
    give_verdict();
  endtask
  task automatic cmd(input logic [7:0] d);
    lcdiu_host_model_inst.xfer(1'b0, 1'b0, d, rdq);
    poll();
  endtask
  // The address must hold right after busy clears and step once the delay has run.
  task automatic dat(input logic rw, input logic [7:0] d, input logic [6:0] a0,
    input logic [6:0] a1);
    lcdiu_host_model_inst.xfer(1'b1, rw, d, got);
    chk("busy pin", 8'h01, {7'h0, busy});
    poll();
    chk("address before step", {1'b0, a0}, {1'b0, ac});
    repeat (805) @(posedge i_sys_clk);
    poll();
    chk("address after step", {1'b0, a1}, {1'b0, ac});
  endtask
  task automatic scan(input logic [6:0] idx, input logic [7:0] e);
    @(posedge i_sys_clk);
    scan_idx <= idx;
    gscan_addr <= 6'h3F;
    repeat (3) @(posedge i_sys_clk);
    #1;
    chk("char ram", e, scan_data);
  endtask
  initial
  begin
    i_rstn = 1'b0;
    scan_idx = 7'h00;
    gscan_addr = 6'h00;
    n_mismatch = 0;
    checks_done = 0;
    repeat (12) @(posedge i_sys_clk);
    i_rstn <= 1'b1;
    #1;
    chk("duty", 8'h08, {3'h0, disp.duty_div});
    scan(7'h4F, 8'h20);
    cmd(8'h38);
    chk("read drive seen", 8'h01, {7'h0, oe_seen});
    chk("read drive", 8'h00, {7'h0, db_oe});
    chk("duty", 8'h10, {3'h0, disp.duty_div});
    cmd(8'h24);
    chk("duty", 8'h0B, {3'h0, disp.duty_div});
    cmd(8'h0F);
    chk("cursor row", 8'h0A, {4'h0, disp.cursor_row});
    for (int k = 0; k < 2; k++)
    begin
      blink_was = disp.blink_show;
      n = 0;
      while (disp.blink_show === blink_was && n < 40)
      begin
        @(posedge i_sys_clk);
        #1;
        n++;
      end
    end
    chk("blink interval", 8'(T_BLINK), 8'(n));
    cmd(8'h80);
    dat(1'b0, 8'h5A, 7'h00, 7'h01);
    scan(7'h00, 8'h5A);
    cmd(8'h80);
    dat(1'b1, 8'h00, 7'h00, 7'h01);
    chk("read data", 8'h5A, got);
    cmd(8'h38);
    cmd(8'h08);
    chk("display on", 8'h00, {7'h0, disp.display_on});
    lcdiu_host_model_inst.xfer(1'b0, 1'b0, 8'h0C, rdq);
    lcdiu_host_model_inst.xfer(1'b0, 1'b0, 8'h08, rdq);
    poll();
    chk("display on", 8'h01, {7'h0, disp.display_on});
    scan(7'h00, 8'h5A);
    cmd(8'hA7);
    dat(1'b0, 8'h41, 7'h27, 7'h40);
    scan(7'h27, 8'h41);
    cmd(8'h07);
    dat(1'b0, 8'h42, 7'h40, 7'h41);
    ofs(8'h01);
    scan(7'h28, 8'h42);
    cmd(8'h05);
    dat(1'b0, 8'h43, 7'h41, 7'h40);
    ofs(8'h00);
    dat(1'b1, 8'h00, 7'h40, 7'h27);
    chk("read data", 8'h42, got);
    ofs(8'h00);
    for (int k = 0; k < 4; k++)
    begin
      cmd(SH_TAB[k][23:16]);
      ofs(SH_TAB[k][15:8]);
      chk("address", SH_TAB[k][7:0], {1'b0, ac});
    end
    cmd(8'h18);
    cmd(8'h02);
    ofs(8'h00);
    chk("address", 8'h00, {1'b0, ac});
    scan(7'h27, 8'h41);
    cmd(8'h18);
    cmd(8'h01);
    ofs(8'h00);
    chk("address", 8'h00, {1'b0, ac});
    scan(7'h27, 8'h20);
    dat(1'b0, 8'h44, 7'h00, 7'h01);
    ofs(8'h01);
    cmd(8'h7F);
    dat(1'b0, 8'h15, 7'h3F, 7'h00);
    ofs(8'h01);
    scan(7'h00, 8'h44);
    chk("glyph ram", 8'h15, gscan_data);
    give_verdict();
  end
endmodule // tb_top
